// ===== bench/sps_front_model.sv
`timescale 1ns/10ps
`default_nettype none
module sps_front_model (
  // clock and supply levels
  input wire logic clock,
  input wire logic bo_cmd,
  input wire logic deep_cmd,
  // monitor pins and requests
  output logic supply_above_bo,
  output logic supply_above_deep,
  output var logic coil_drive_a_req,
  output var logic coil_drive_b_req,
  output var logic diag_error_n
);
  // below the deep level the supply is below the brownout level too
  assign supply_above_bo = bo_cmd && deep_cmd;
  assign supply_above_deep = deep_cmd;
  initial {coil_drive_a_req, coil_drive_b_req, diag_error_n} = 3'h0;
  always @(posedge clock) {coil_drive_a_req, coil_drive_b_req, diag_error_n} <= 3'($urandom);
endmodule // sps_front_model
`default_nettype wire

// ===== bench/sps_sequencer_checker.sv
`timescale 1ns/10ps
`default_nettype none
module sps_sequencer_checker
  import sps_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned LOOP_CYCLES = LOOP_CYC,
  parameter int unsigned FILT_CYCLES = FILT_CYC
) (
  // inputs
  input wire logic clock,
  input wire logic rst,
  input wire logic supply_above_bo,
  input wire logic supply_above_deep,
  input wire logic coil_drive_a_req,
  input wire logic coil_drive_b_req,
  input wire logic diag_error_n,
  input wire logic reg_rd,
  // outputs
  input wire logic sensor_en,
  input wire logic loop_en,
  input wire logic coil_drive_a,
  input wire logic coil_drive_b,
  input wire logic error_n,
  input wire logic [DATA_W-1:0] reg_rdata
);
  int up;
  int lo;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      up <= 0;
      lo <= 0;
    end else begin
      up <= (supply_above_bo && supply_above_deep) ? up + 1 : 0;
      lo <= supply_above_bo ? 0 : lo + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_settle; $rose(sensor_en) |-> up == SETTLE_CYCLES + 2; endproperty
  a_settle: assert property (p_settle) else $error("sensor enable off time");
  property p_loop; $rose(loop_en) |-> up == LOOP_CYCLES + 2; endproperty
  a_loop: assert property (p_loop) else $error("loop enable off time");
  property p_order; loop_en |-> sensor_en; endproperty
  a_order: assert property (p_order) else $error("loop before sensor");
  property p_hold; !loop_en |-> !coil_drive_a && !coil_drive_b && !error_n; endproperty
  a_hold: assert property (p_hold) else $error("outputs free early");
  property p_filt; lo >= FILT_CYCLES + 4 |-> !sensor_en; endproperty
  a_filt: assert property (p_filt) else $error("long dip kept running");
  property p_deep; !supply_above_deep |-> ##4 !sensor_en && !loop_en; endproperty
  a_deep: assert property (p_deep) else $error("deep drop kept running");
  property p_follow;
    loop_en && $past(loop_en) |-> coil_drive_a == $past(coil_drive_a_req)
      && coil_drive_b == $past(coil_drive_b_req) && error_n == $past(diag_error_n);
  endproperty
  a_follow: assert property (p_follow) else $error("outputs not released");
  property p_rdata; !$past(reg_rd) |-> reg_rdata == '0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule // sps_sequencer_checker
`default_nettype wire

// ===== bench/sps_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sps_sequencer_tb;
  import sps_pkg::*;
  localparam int S = 10;
  localparam int L = 30;
  localparam int F = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic bo = 1'b0;
  logic deep = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0;
  wire logic ab, ad, qa, qb, dg, sen, len, ca, cb, en, irq;
  wire logic [DATA_W-1:0] rdata;
  int bad_count = 0;
  int n_tests = 0;
  always #2 clock = ~clock;
  sps_front_model u_fe (.clock(clock), .bo_cmd(bo), .deep_cmd(deep), .supply_above_bo(ab),
    .supply_above_deep(ad), .coil_drive_a_req(qa), .coil_drive_b_req(qb), .diag_error_n(dg));
  sps_sequencer #(.SETTLE_CYCLES(S), .LOOP_CYCLES(L), .FILT_CYCLES(F)) u_dut (.clock(clock),
    .rst(rst), .supply_above_bo(ab), .supply_above_deep(ad), .coil_drive_a_req(qa),
    .coil_drive_b_req(qb), .diag_error_n(dg), .sensor_en(sen), .loop_en(len),
    .coil_drive_a(ca), .coil_drive_b(cb), .error_n(en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq(irq));
  function automatic logic [DATA_W-1:0] ev(input int b);
    return 32'h1 << b;
  endfunction
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // raise both levels and time the start-up; model of outputs kept in pv
  task automatic up_check;
    int ns;
    int nl;
    logic [2:0] pv;
    ns = 0;
    nl = 0;
    pv = 3'h0;
    @(posedge clock);
    bo <= 1'b1;
    deep <= 1'b1;
    for (int n = 1; n <= 45; n++) begin
      cyc(1);
      if (sen === 1'b1 && ns == 0) ns = n;
      if (len === 1'b1 && nl == 0) nl = n;
      if (nl != 0) chk({ca, cb, en}, pv);
      else chk({ca, cb, en}, 3'h0);
      pv = {qa, qb, dg};
    end
    chk(ns, S + 2);
    chk(nl, L + 2);
    if (nl == 0) close_out;
  endtask
  task automatic dip(input int w);
    @(posedge clock);
    bo <= 1'b0;
    cyc(w);
    @(posedge clock);
    bo <= 1'b1;
  endtask
  initial begin
    void'($urandom(70983));
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rreg(REG_STATUS, 32'h0);
    rreg(REG_MASK, 32'h0);
    wreg(8'h10, 32'hFFFFFFFF);
    rreg(8'h10, 32'h0);
    up_check;
    wreg(REG_MASK, 32'hF);
    chk(irq, 1'b1);
    rreg(REG_STATUS, ev(EV_READY));
    wreg(REG_STATUS, 32'hF);
    chk(irq, 1'b0);
    dip(F - 1);
    dip($urandom_range(F - 2, 0));
    cyc(F + 6);
    chk(len, 1'b1);
    rreg(REG_STATUS, ev(EV_DIP));
    wreg(REG_STATUS, 32'hF);
    @(posedge clock);
    bo <= 1'b0;
    cyc(F + 6);
    chk(sen, 1'b0);
    up_check;
    rreg(REG_STATUS, ev(EV_POR) | ev(EV_READY));
    wreg(REG_STATUS, 32'hF);
    @(posedge clock);
    deep <= 1'b0;
    cyc(4);
    chk(sen, 1'b0);
    up_check;
    chk(irq, 1'b1);
    wreg(REG_MASK, 32'h0);
    chk(irq, 1'b0);
    rreg(REG_STATUS, ev(EV_POR) | ev(EV_DEEP) | ev(EV_READY));
    // soft power-on reset: outputs drop, sequence restarts from settle
    wreg(REG_STATUS, 32'hF);
    wreg(REG_CTRL, ev(CTRL_SOFT_POR));
    chk(sen, 1'b0);
    chk(len, 1'b0);
    rreg(REG_STATE, (32'(SPS_SETTLE) << STF_STATE_LSB) | (32'h3 << STF_SUP_LSB));
    rreg(REG_CTRL, 32'h0);
    rreg(REG_STATUS, ev(EV_POR));
    close_out;
  end
endmodule // sps_sequencer_tb
bind sps_sequencer sps_sequencer_checker #(.SETTLE_CYCLES(SETTLE_CYCLES),
  .LOOP_CYCLES(LOOP_CYCLES), .FILT_CYCLES(FILT_CYCLES)) u_chk (.clock(clock), .rst(rst),
  .supply_above_bo(supply_above_bo), .supply_above_deep(supply_above_deep),
  .coil_drive_a_req(coil_drive_a_req), .coil_drive_b_req(coil_drive_b_req),
  .diag_error_n(diag_error_n), .reg_rd(reg_rd), .sensor_en(sensor_en), .loop_en(loop_en),
  .coil_drive_a(coil_drive_a), .coil_drive_b(coil_drive_b), .error_n(error_n),
  .reg_rdata(reg_rdata));
`default_nettype wire

// ===== src/sps_bo_filter.sv
`timescale 1ns/10ps
`default_nettype none

module sps_bo_filter
  import sps_pkg::*;
#(
  parameter int unsigned FILT_CYCLES = FILT_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control and level
  input wire logic clear,
  input wire logic below,
  // results
  output logic trip,
  output logic dip_ignored
);

  if (FILT_CYCLES < 1 || FILT_CYCLES >= (1 << CNT_W)) begin : g_bad_filt
    $error("sps_bo_filter: FILT_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] FILT_MAX = CNT_W'(FILT_CYCLES);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic trip;
    logic dip;
  } sps_filt_st_t;

  sps_filt_st_t s;
  sps_filt_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.trip = 1'b0;
    next_s.dip = 1'b0;
    if (clear) begin
      next_s.cnt = '0;
    end else if (below) begin
      if (s.cnt == FILT_MAX) begin
        next_s.trip = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end else begin
      next_s.dip = (s.cnt != '0);
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign trip = s.trip;
  assign dip_ignored = s.dip;

endmodule // sps_bo_filter

`default_nettype wire

// ===== src/sps_pkg.sv
package sps_pkg;

  // clock rate
  localparam int unsigned CLK_MHZ = 250;

  // start-up and brownout times, in ns
  localparam int unsigned SETTLE_NS = 26000;
  localparam int unsigned LOOP_NS = 70000;
  localparam int unsigned FILT_NS = 20000;

  // times as clock cycles, rounded up
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LOOP_CYC = (LOOP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;

  // counter width
  localparam int unsigned CNT_W = 16;

  // register port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register offsets
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h0C;

  // event bits of status and mask
  localparam int unsigned EV_POR = 0;
  localparam int unsigned EV_DEEP = 1;
  localparam int unsigned EV_DIP = 2;
  localparam int unsigned EV_READY = 3;
  localparam int unsigned EV_N = 4;

  // control bits
  localparam int unsigned CTRL_SOFT_POR = 0;

  // state register fields
  localparam int unsigned STF_STATE_LSB = 0;
  localparam int unsigned STF_SUP_LSB = 4;
  localparam int unsigned STF_OUT_LSB = 8;

  // reset values
  localparam logic [EV_N-1:0] STATUS_RST = 4'h0;
  localparam logic [EV_N-1:0] MASK_RST = 4'h0;

  // sequencer states
  typedef enum logic [3:0] {
    SPS_POR = 4'h1,
    SPS_SETTLE = 4'h2,
    SPS_SENSOR = 4'h4,
    SPS_RUN = 4'h8
  } sps_state_t;

  // supply monitor levels
  typedef struct packed {
    logic above_bo;
    logic above_deep;
  } sps_supply_t;

  // sequencer drive outputs
  typedef struct packed {
    logic sensor_en;
    logic loop_en;
    logic coil_drive_a;
    logic coil_drive_b;
    logic error_n;
  } sps_drive_t;

  localparam sps_drive_t DRIVE_OFF = '{
    sensor_en: 1'b0,
    loop_en: 1'b0,
    coil_drive_a: 1'b0,
    coil_drive_b: 1'b0,
    error_n: 1'b0
  };

endpackage

// ===== src/sps_sequencer.sv
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module sps_sequencer
  import sps_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned LOOP_CYCLES = LOOP_CYC,
  parameter int unsigned FILT_CYCLES = FILT_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // supply monitor pins
  input wire logic supply_above_bo,
  input wire logic supply_above_deep,
  // requests from the loop and diagnostics
  input wire logic coil_drive_a_req,
  input wire logic coil_drive_b_req,
  input wire logic diag_error_n,
  // front end controls
  output logic sensor_en,
  output logic loop_en,
  output logic coil_drive_a,
  output logic coil_drive_b,
  output logic error_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // interrupt
  output logic irq
);

  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= LOOP_CYCLES) begin : g_bad_settle
    $error("sps_sequencer: SETTLE_CYCLES must be at least 1 and below LOOP_CYCLES");
  end
  if (LOOP_CYCLES >= (1 << CNT_W)) begin : g_bad_loop
    $error("sps_sequencer: LOOP_CYCLES does not fit the counter");
  end

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] LOOP_LAST = CNT_W'(LOOP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_FIRST = CNT_W'(1);

  typedef struct packed {
    sps_state_t state;
    logic [CNT_W-1:0] cnt;
    sps_drive_t drv;
    logic [EV_N-1:0] status;
    logic [EV_N-1:0] mask;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } sps_seq_st_t;

  localparam sps_seq_st_t ST_RST = '{
    state: SPS_POR,
    cnt: '0,
    drv: DRIVE_OFF,
    status: STATUS_RST,
    mask: MASK_RST,
    irq: 1'b0,
    rdata: '0
  };

  sps_seq_st_t s;
  sps_seq_st_t next_s;

  // synchronised supply levels
  sps_supply_t sup_pin;
  sps_supply_t sup;

  assign sup_pin.above_bo = supply_above_bo;
  assign sup_pin.above_deep = supply_above_deep;

  sps_sync u_sync (
    .clock(clock),
    .rst(rst),
    .d(sup_pin),
    .q(sup)
  );

  // brownout filter, cleared while in power-on reset
  logic filt_clear;
  logic bo_trip;
  logic dip_ignored;

  assign filt_clear = (s.state == SPS_POR);

  sps_bo_filter #(
    .FILT_CYCLES(FILT_CYCLES)
  ) u_filter (
    .clock(clock),
    .rst(rst),
    .clear(filt_clear),
    .below(!sup.above_bo),
    .trip(bo_trip),
    .dip_ignored(dip_ignored)
  );

  // decoded register accesses
  logic wr_status;
  logic wr_mask;
  logic wr_ctrl;
  logic soft_por;
  logic deep_low;
  logic por_now;
  logic [EV_N-1:0] ev_set;

  always_comb begin
    wr_status = 1'b0;
    wr_mask = 1'b0;
    wr_ctrl = 1'b0;
    if (reg_wr) begin
      if (reg_addr == REG_STATUS) begin
        wr_status = 1'b1;
      end else if (reg_addr == REG_MASK) begin
        wr_mask = 1'b1;
      end else if (reg_addr == REG_CTRL) begin
        wr_ctrl = 1'b1;
      end
    end
  end

  assign soft_por = wr_ctrl && reg_wdata[CTRL_SOFT_POR];
  assign deep_low = !sup.above_deep;
  assign por_now = deep_low || bo_trip || soft_por;

  always_comb begin
    next_s = s;
    ev_set = '0;

    // sequencer
    case (s.state)
      SPS_POR: begin
        next_s.cnt = '0;
        next_s.drv = DRIVE_OFF;
        if (sup.above_bo && sup.above_deep) begin
          next_s.state = SPS_SETTLE;
          next_s.cnt = CNT_FIRST;
        end
      end
      SPS_SETTLE: begin
        next_s.cnt = s.cnt + 1'b1;
        next_s.drv.coil_drive_a = 1'b0;
        next_s.drv.coil_drive_b = 1'b0;
        next_s.drv.error_n = 1'b0;
        if (s.cnt == SETTLE_LAST) begin
          next_s.state = SPS_SENSOR;
          next_s.drv.sensor_en = 1'b1;
        end
      end
      SPS_SENSOR: begin
        next_s.cnt = s.cnt + 1'b1;
        next_s.drv.coil_drive_a = 1'b0;
        next_s.drv.coil_drive_b = 1'b0;
        next_s.drv.error_n = 1'b0;
        if (s.cnt == LOOP_LAST) begin
          next_s.state = SPS_RUN;
          next_s.drv.loop_en = 1'b1;
          next_s.drv.coil_drive_a = coil_drive_a_req;
          next_s.drv.coil_drive_b = coil_drive_b_req;
          next_s.drv.error_n = diag_error_n;
          ev_set[EV_READY] = 1'b1;
        end
      end
      SPS_RUN: begin
        next_s.cnt = '0;
        next_s.drv.sensor_en = 1'b1;
        next_s.drv.loop_en = 1'b1;
        next_s.drv.coil_drive_a = coil_drive_a_req;
        next_s.drv.coil_drive_b = coil_drive_b_req;
        next_s.drv.error_n = diag_error_n;
      end
      default: begin
        next_s.state = SPS_POR;
        next_s.cnt = '0;
        next_s.drv = DRIVE_OFF;
      end
    endcase

    // any power-on reset cause wins over the sequence
    if (por_now) begin
      next_s.state = SPS_POR;
      next_s.cnt = '0;
      next_s.drv = DRIVE_OFF;
      if (s.state != SPS_POR) begin
        ev_set[EV_POR] = 1'b1;
        ev_set[EV_DEEP] = deep_low;
      end
    end
    ev_set[EV_DIP] = dip_ignored && (s.state != SPS_POR);

    // status: write one to clear, a new event wins
    if (wr_status) begin
      next_s.status = s.status & ~reg_wdata[EV_N-1:0];
    end
    next_s.status = next_s.status | ev_set;

    if (wr_mask) begin
      next_s.mask = reg_wdata[EV_N-1:0];
    end

    next_s.irq = |(next_s.status & next_s.mask);

    // read data stands one cycle only
    next_s.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == REG_STATUS) begin
        next_s.rdata[EV_N-1:0] = s.status;
      end else if (reg_addr == REG_MASK) begin
        next_s.rdata[EV_N-1:0] = s.mask;
      end else if (reg_addr == REG_CTRL) begin
        next_s.rdata = '0;
      end else if (reg_addr == REG_STATE) begin
        next_s.rdata[STF_STATE_LSB +: $bits(sps_state_t)] = s.state;
        next_s.rdata[STF_SUP_LSB] = sup.above_deep;
        next_s.rdata[STF_SUP_LSB + 1] = sup.above_bo;
        next_s.rdata[STF_OUT_LSB +: $bits(sps_drive_t)] = s.drv;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  assign sensor_en = s.drv.sensor_en;
  assign loop_en = s.drv.loop_en;
  assign coil_drive_a = s.drv.coil_drive_a;
  assign coil_drive_b = s.drv.coil_drive_b;
  assign error_n = s.drv.error_n;
  assign reg_rdata = s.rdata;
  assign irq = s.irq;

endmodule // sps_sequencer

`default_nettype wire

// ===== src/sps_sync.sv
`timescale 1ns/10ps
`default_nettype none

module sps_sync
  import sps_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pin levels in, synchronised levels out
  input wire sps_supply_t d,
  output sps_supply_t q
);

  typedef struct packed {
    sps_supply_t meta;
    sps_supply_t held;
  } sps_sync_st_t;

  sps_sync_st_t s;
  sps_sync_st_t next_s;

  always_comb begin
    next_s.meta = d;
    next_s.held = s.meta;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.held;

endmodule // sps_sync

`default_nettype wire
